// ==== core/osc_output_regs.sv ====
`timescale 1ns/1ps
module osc_output_regs #(
    parameter int unsigned OFF_LONG  = osc_pkg::OSC_OFF_LONG_CYC,
    parameter int unsigned OFF_SHORT = osc_pkg::OSC_OFF_SHORT_CYC
) (
    input  wire logic                               sys_clk,
    input  wire logic                               srst,
    input  wire logic                               ce,
    input  wire logic                               device_enable,
    input  wire logic                               ctrl_wr,
    input  wire logic [osc_pkg::OSC_REG_W-1:0]      ctrl_wdata,
    input  wire logic [osc_pkg::OSC_NUM_DRV-1:0]    pulse_enable,
    input  wire logic [osc_pkg::OSC_NUM_DRV-1:0]    recovery_enable,
    input  wire logic                               pulse_input_a,
    input  wire logic                               pulse_input_b,
    input  wire logic [osc_pkg::OSC_NUM_DRV-1:0]    oc_event,
    input  wire logic [osc_pkg::OSC_EXT_W-1:0]      ext_flags,
    output logic [osc_pkg::OSC_NUM_DRV-1:0]         drive_q,
    output logic [osc_pkg::OSC_REG_W-1:0]           status_q,
    output logic                                    active_q
);
    import osc_pkg::*;

    logic [OSC_REG_W-1:0]   ctrl_q;
    logic [OSC_NUM_DRV-1:0] sw_req;
    logic [OSC_NUM_DRV-1:0] gated;
    logic [OSC_NUM_DRV-1:0] safe;
    logic [OSC_NUM_DRV-1:0] flag;
    logic [OSC_NUM_DRV-1:0] allow;
    logic [OSC_NUM_DRV-1:0] oc_live;
    logic [OSC_REG_W-1:0]   status_d;
    logic                   host_clr;
    logic                   cell_clr;
    logic                   any_flag;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            active_q <= 1'b0;
        end else if (ce) begin
            active_q <= device_enable;
        end
    end

    // The reset bit acts once per write and is not stored.
    assign host_clr = ctrl_wr && ctrl_wdata[OSC_RESET_BIT];
    assign cell_clr = host_clr || !active_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q <= OSC_CTRL_RST;
        end else if (ce) begin
            if (!active_q) begin
                ctrl_q <= OSC_CTRL_RST;
            end else if (ctrl_wr) begin
                ctrl_q <= ctrl_wdata;
                ctrl_q[OSC_RESET_BIT] <= 1'b0;
            end
        end
    end

    // Trips are only meaningful while a driver is actually switched on.
    assign oc_live = oc_event & drive_q;

    for (genvar i = 0; i < OSC_NUM_DRV; i++) begin : g_cell
        osc_prot_cell #(
            .CNT_W     (OSC_CNT_W),
            .OFF_LONG  (OFF_LONG),
            .OFF_SHORT (OFF_SHORT)
        ) u_cell (
            .sys_clk  (sys_clk),
            .srst     (srst),
            .ce       (ce),
            .clr      (cell_clr),
            .rec_en   (recovery_enable[i]),
            .duty_sel (ctrl_q[OSC_DUTY_BIT]),
            .oc_event (oc_live[i]),
            .flag_q   (flag[i]),
            .allow_q  (allow[i])
        );
    end

    // pick switch bits out of the control word.
    always_comb begin
        for (int i = 0; i < OSC_NUM_DRV; i++) begin
            sw_req[i] = ctrl_q[OSC_DRV_BIT[i]];
        end
    end

    always_comb begin
        for (int i = 0; i < OSC_NUM_DRV; i++) begin
            if (pulse_enable[i]) begin
                gated[i] = sw_req[i] &&
                    (OSC_PULSE_SEL_B[i] ? pulse_input_b : pulse_input_a);
            end else begin
                gated[i] = sw_req[i];
            end
        end
    end

    always_comb begin
        safe = gated;
        for (int b = 0; b < OSC_NUM_BRIDGE; b++) begin
            if (gated[2*b] && gated[2*b+1]) begin
                safe[2*b]   = 1'b0;
                safe[2*b+1] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            drive_q <= '0;
        end else if (ce) begin
            if (!active_q) begin
                drive_q <= '0;
            end else begin
                drive_q <= safe & allow & ~oc_live;
            end
        end
    end

    // Status word assembly; unused bit positions read zero.
    always_comb begin
        status_d = '0;
        for (int i = 0; i < OSC_NUM_DRV; i++) begin
            status_d[OSC_DRV_BIT[i]] = flag[i];
        end
    end

    assign any_flag = (|status_d) || (|ext_flags);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            status_q <= OSC_STATUS_RST;
        end else if (ce) begin
            status_q <= status_d;
            status_q[OSC_NO_ERR_BIT] <= ~any_flag;
        end
    end

endmodule

// ==== core/osc_pkg.sv ====
package osc_pkg;

    // Register word width and driver count.
    localparam int unsigned OSC_REG_W      = 24;
    localparam int unsigned OSC_NUM_DRV    = 9;
    localparam int unsigned OSC_NUM_BRIDGE = 3;
    localparam int unsigned OSC_EXT_W      = 44;

    // Control word fields.
    localparam int unsigned OSC_RESET_BIT = 22;
    localparam int unsigned OSC_DUTY_BIT  = 21;

    // Status word fields.
    localparam int unsigned OSC_NO_ERR_BIT = 0;

    // Driver bit positions, lower then upper per bridge, then high sides.
    localparam int unsigned OSC_DRV_BIT [0:OSC_NUM_DRV-1] =
        '{1, 2, 3, 4, 5, 6, 14, 15, 17};

    // Which pulse input gates each driver: 0 selects a, 1 selects b.
    localparam logic [OSC_NUM_DRV-1:0] OSC_PULSE_SEL_B = 9'h1C0;

    // Values after reset.
    localparam logic [OSC_REG_W-1:0] OSC_CTRL_RST   = 24'h000000;
    localparam logic [OSC_REG_W-1:0] OSC_STATUS_RST = 24'h000001;

    // Recovery off times in ns for the two duty settings.
    localparam int unsigned OSC_CLK_MHZ      = 100;
    localparam int unsigned OSC_OFF_LONG_NS  = 2000;
    localparam int unsigned OSC_OFF_SHORT_NS = 500;
    localparam int unsigned OSC_OFF_LONG_CYC =
        (OSC_OFF_LONG_NS * OSC_CLK_MHZ + 999) / 1000;
    localparam int unsigned OSC_OFF_SHORT_CYC =
        (OSC_OFF_SHORT_NS * OSC_CLK_MHZ + 999) / 1000;
    localparam int unsigned OSC_CNT_W = 16;

    // Protection cell states, Gray coded along the trip and retry path.
    typedef enum logic [1:0] {
        OSC_ST_ARMED   = 2'h0,
        OSC_ST_TRIPPED = 2'h1,
        OSC_ST_RETRY   = 2'h3
    } osc_state_t;

endpackage

// ==== core/osc_prot_cell.sv ====
`timescale 1ns/1ps
module osc_prot_cell #(
    parameter int unsigned CNT_W     = osc_pkg::OSC_CNT_W,
    parameter int unsigned OFF_LONG  = osc_pkg::OSC_OFF_LONG_CYC,
    parameter int unsigned OFF_SHORT = osc_pkg::OSC_OFF_SHORT_CYC
) (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic clr,
    input  wire logic rec_en,
    input  wire logic duty_sel,
    input  wire logic oc_event,
    output logic      flag_q,
    output logic      allow_q
);
    import osc_pkg::*;

    osc_state_t       state_q;
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flag_q <= 1'b0;
        end else if (ce) begin
            if (oc_event) begin
                flag_q <= 1'b1;
            end else if (clr) begin
                flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= OSC_ST_ARMED;
            cnt_q   <= '0;
            allow_q <= 1'b1;
        end else if (ce) begin
            case (state_q)
                OSC_ST_ARMED: begin
                    allow_q <= ~oc_event;
                    if (oc_event) begin
                        state_q <= OSC_ST_TRIPPED;
                    end
                end
                OSC_ST_TRIPPED: begin
                    allow_q <= 1'b0;
                    cnt_q   <= duty_sel ? CNT_W'(OFF_SHORT - 1)
                                        : CNT_W'(OFF_LONG - 1);
                    if (clr && !oc_event) begin
                        state_q <= OSC_ST_ARMED;
                        allow_q <= 1'b1;
                    end else if (rec_en) begin
                        state_q <= OSC_ST_RETRY;
                    end
                end
                OSC_ST_RETRY: begin
                    allow_q <= 1'b0;
                    cnt_q   <= cnt_q - CNT_W'(1);
                    if (oc_event) begin
                        state_q <= OSC_ST_TRIPPED;
                    end else if (cnt_q == '0 || clr) begin
                        state_q <= OSC_ST_ARMED;
                        allow_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= OSC_ST_ARMED;
                    allow_q <= 1'b1;
                end
            endcase
        end
    end

endmodule

// ==== test/osc_host_model.sv ====
`timescale 1ns/1ps
module osc_host_model (
    input  wire logic                     sys_clk,
    output logic                          ctrl_wr,
    output logic [osc_pkg::OSC_REG_W-1:0] ctrl_wdata
);
    import osc_pkg::*;
    initial begin
        ctrl_wr = 1'b0;
        ctrl_wdata = '0;
    end
    // flag clear: bit 22 of a word clears latched flags.
    task automatic write(input logic [OSC_REG_W-1:0] w);
        @(posedge sys_clk) #1;
        ctrl_wr = 1'b1;
        ctrl_wdata = w;
        @(posedge sys_clk) #1;
        ctrl_wr = 1'b0;
        ctrl_wdata = ~w;
    endtask
endmodule

// ==== test/osc_output_regs_chk.sv ====
`timescale 1ns/1ps
module osc_output_regs_chk import osc_pkg::*; #(
    parameter int unsigned OFF_LONG  = OSC_OFF_LONG_CYC,
    parameter int unsigned OFF_SHORT = OSC_OFF_SHORT_CYC
) (
    input wire logic                   sys_clk,
    input wire logic                   srst,
    input wire logic                   ce,
    input wire logic                   device_enable,
    input wire logic                   ctrl_wr,
    input wire logic [OSC_REG_W-1:0]   ctrl_wdata,
    input wire logic [OSC_NUM_DRV-1:0] pulse_enable,
    input wire logic                   pulse_input_a,
    input wire logic                   pulse_input_b,
    input wire logic [OSC_NUM_DRV-1:0] oc_event,
    input wire logic [OSC_EXT_W-1:0]   ext_flags,
    input wire logic [OSC_NUM_DRV-1:0] drive_q,
    input wire logic [OSC_REG_W-1:0]   status_q,
    input wire logic                   active_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    chk_bridge_safe: assert property (
        (drive_q[5:0] & (drive_q[5:0] >> 1) & 6'h15) == 6'h00)
        else $error("both bridge drivers on");
    chk_unused_zero: assert property (
        status_q[16] == 1'b0 && status_q[13:7] == 7'h00)
        else $error("unused status bit set");
    chk_noerr_low: assert property (
        (|status_q[22:1]) || (|$past(ext_flags)) |-> !status_q[0])
        else $error("no error bit high with flags");
    chk_noerr_high: assert property (
        $past(ce) && status_q[22:1] == 22'h0 && $past(ext_flags) == '0
        && $past(status_q[22:1]) == 22'h0 |-> status_q[0])
        else $error("no error bit low without flags");
    chk_standby_off: assert property (!active_q [*2] |-> drive_q == '0)
        else $error("driver on in standby");
    chk_wake_up: assert property (
        ce && device_enable && !active_q |=> active_q)
        else $error("active mode not entered");
    for (genvar i = 0; i < OSC_NUM_DRV; i++) begin : g_drv
        sequence s_trip;
            ce && active_q && oc_event[i] && drive_q[i];
        endsequence
        sequence s_clear;
            ce && active_q && ctrl_wr && !ctrl_wdata[OSC_DRV_BIT[i]] ##1 ce;
        endsequence
        chk_oc_trip: assert property (
            s_trip |=> !drive_q[i] ##1 status_q[OSC_DRV_BIT[i]])
            else $error("over-current not handled");
        chk_pulse_gate: assert property (ce && pulse_enable[i] &&
            !(OSC_PULSE_SEL_B[i] ? pulse_input_b : pulse_input_a)
            |=> !drive_q[i])
            else $error("driver on while pulse input low");
        chk_switch_off: assert property (s_clear |=> !drive_q[i])
            else $error("driver on after switch cleared");
    end
endmodule
bind osc_output_regs osc_output_regs_chk #(.OFF_LONG(OFF_LONG),
    .OFF_SHORT(OFF_SHORT)) osc_output_regs_chk_i (.sys_clk(sys_clk),
    .srst(srst), .ce(ce), .device_enable(device_enable),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .pulse_enable(pulse_enable), .pulse_input_a(pulse_input_a),
    .pulse_input_b(pulse_input_b), .oc_event(oc_event),
    .ext_flags(ext_flags), .drive_q(drive_q), .status_q(status_q),
    .active_q(active_q));

// ==== test/osc_output_regs_test.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    errors++; $display("wrong value %0t %h %h", $time, (a), (e)); end end
module osc_output_regs_test;
    import osc_pkg::*;
    localparam int LONG = 4;
    localparam int SHORT = 2;
    logic                   sys_clk = 0, srst = 1, device_enable = 0;
    logic                   pulse_input_a = 0, pulse_input_b = 0;
    logic [OSC_NUM_DRV-1:0] pulse_enable = 0, recovery_enable = 0;
    logic [OSC_NUM_DRV-1:0] oc_event = 0, drive_q;
    logic [OSC_EXT_W-1:0]   ext_flags = 0;
    logic [OSC_REG_W-1:0]   ctrl_wdata, status_q;
    logic                   ctrl_wr, active_q;
    logic                   ce = 1'b1;
    int                     errors = 0, samples_checked = 0;
    osc_output_regs #(.OFF_LONG(LONG), .OFF_SHORT(SHORT)) osc_output_regs_i (
        .sys_clk(sys_clk), .srst(srst), .ce(ce),
        .device_enable(device_enable), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .pulse_enable(pulse_enable),
        .recovery_enable(recovery_enable), .pulse_input_a(pulse_input_a),
        .pulse_input_b(pulse_input_b), .oc_event(oc_event),
        .ext_flags(ext_flags), .drive_q(drive_q), .status_q(status_q),
        .active_q(active_q));
    osc_host_model osc_host_model_i (.sys_clk(sys_clk), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata));
    initial forever #5 sys_clk = ~sys_clk;
    task automatic step(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [OSC_REG_W-1:0] w);
        osc_host_model_i.write(w);
        step();
    endtask
    task automatic t_start;
        `CHK(status_q, OSC_STATUS_RST)
        wr(24'hFFFFFF);
        device_enable = 1;
        step(2);
        `CHK(active_q, 1'b1)
        `CHK(drive_q, 9'h000)
    endtask
    task automatic t_switch;
        wr(24'h03FFB2);
        `CHK(drive_q, 9'h1D9)
        wr(24'h020006);
        `CHK(drive_q, 9'h100)
    endtask
    task automatic t_pulse;
        pulse_enable = 9'h1FF;
        pulse_input_b = 1;
        wr(24'h02C02A);
        `CHK(drive_q, 9'h1C0)
        pulse_input_a = 1;
        pulse_input_b = 0;
        step();
        `CHK(drive_q, 9'h015)
        pulse_enable = 0;
        step();
        `CHK(drive_q, 9'h1D5)
    endtask
    task automatic t_latch;
        oc_event[6] = 1;
        step(2);
        `CHK(status_q, 24'h004000)
        step(20);
        `CHK(drive_q, 9'h195)
        oc_event[6] = 0;
        wr(24'h42C02A);
        step();
        `CHK(status_q, 24'h000001)
        `CHK(drive_q, 9'h1D5)
    endtask
    task automatic t_retry(input logic duty, input int exp);
        int n;
        n = 0;
        recovery_enable = 9'h100;
        wr({2'b00, duty, 21'h02C02A});
        oc_event[8] = 1;
        step();
        oc_event[8] = 0;
        while (drive_q[8] !== 1'b1 && n < 50) begin
            step();
            n++;
        end
        `CHK(n, exp)
        `CHK(status_q[17], 1'b1)
        wr(24'h42C02A);
        step();
    endtask
    task automatic t_freeze;
        ce = 1'b0;
        device_enable = 0;
        step(3);
        `CHK({active_q, drive_q}, 10'h3D5)
        ce = 1'b1;
        device_enable = 1;
        step();
        `CHK({active_q, drive_q}, 10'h3D5)
    endtask
    task automatic t_misc;
        wr(24'h00002A);
        `CHK(drive_q, 9'h015)
        ext_flags = 44'h1;
        step(2);
        `CHK(status_q[0], 1'b0)
        ext_flags = 0;
        oc_event[0] = 1;
        step(2);
        oc_event[0] = 0;
        device_enable = 0;
        step(3);
        `CHK({active_q, drive_q}, 10'h000)
        `CHK(status_q, 24'h000001)
    endtask
    task automatic final_report;
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #20000;
        errors++;
        final_report();
    end
    initial begin
        step(8);
        srst = 0;
        t_start();
        t_switch();
        t_pulse();
        t_latch();
        t_retry(1'b0, 2 + LONG);
        t_retry(1'b1, 2 + SHORT);
        t_freeze();
        t_misc();
        final_report();
    end
endmodule
